/* src/uefm_core.sv */
`timescale 1ns/1ps
`default_nettype none
module uefm_core
    import uefm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire uefm_cfg_arr_t ep_cfg,
    input wire logic wr_open,
    input wire uefm_ch_t wr_ch,
    input wire logic wr_valid,
    input wire uefm_beat_t wr_beat,
    output logic wr_ready,
    input wire logic rd_open,
    input wire uefm_ch_t rd_ch,
    output logic out_valid,
    output uefm_beat_t out_beat,
    input wire logic out_ready,
    output logic [UEFM_NCH-1:0] pkt_avail,
    output logic [UEFM_NCH-1:0] space_avail,
    output logic overflow,
    output logic truncated
);
    ////////////////////////////////////////////////////////////////////////
    uefm_wst_t wst_q, wst_d;
    uefm_rdst_t rdst_q;
    uefm_ch_t wch_q, rch_q, cch_q;
    logic [10:0] wcnt_q, rcnt_q, rlen_q;
    logic wtrunc_q, wr_ready_q, wr_ready_d, ovf_q, ovf_d, trunc_q, cslot_q;
    logic [1:0] full_q [16];
    logic [1:0] full_d [16];
    logic [10:0] len_q [16][2];
    logic [15:0] wslot_q, rslot_q;
    logic rv_q, rlast_q, out_valid_q;
    logic [1:0] cnt_q;
    uefm_beat_t h_q, t_q, rbeat;
    logic [UEFM_NCH-1:0] pkt_q, space_q, pkt_d, space_d;
    logic [7:0] rdata;

    ////////////////////////////////////////////////////////////////////////
    // Write side decode
    uefm_region_t wreg, rreg, oreg;
    logic [10:0] wslot_sz, rslot_sz;
    assign wreg = uefm_region(wch_q, ep_cfg);
    assign rreg = uefm_region(rch_q, ep_cfg);
    assign oreg = uefm_region(wr_ch, ep_cfg);
    assign wslot_sz = uefm_slot_sz(wch_q, ep_cfg);
    assign rslot_sz = uefm_slot_sz(rch_q, ep_cfg);

    wire logic w_dbl = uefm_dbl(wch_q, ep_cfg);
    wire logic w_iso = ep_cfg[wch_q.ep].iso && wch_q.ep != 3'h0;
    wire logic w_full = full_q[wch_q][wslot_q[wch_q]];
    wire logic w_beat = wr_valid && wr_ready_q;
    wire logic w_fit = wcnt_q < wslot_sz;
    wire logic w_mem = w_beat && wst_q == W_DATA && w_fit;
    wire logic w_commit = w_beat && wr_beat.last && wst_q == W_DATA;
    wire logic [9:0] w_addr = uefm_addr(wreg, wslot_sz, wslot_q[wch_q],
                                       wcnt_q);

    // Read side decode
    wire logic r_avail = full_q[rd_ch][rslot_q[rd_ch]];
    wire logic r_go = rd_open && rdst_q == R_IDLE && r_avail;
    wire logic r_zero = r_go && len_q[rd_ch][rslot_q[rd_ch]] == 11'h000;
    wire logic r_issue = rdst_q == R_RUN && (cnt_q + {1'h0, rv_q}) < 2'h2;
    wire logic r_end = r_issue && rcnt_q == rlen_q - 11'h001;
    wire logic r_free = r_end || r_zero;
    wire uefm_ch_t fch = r_zero ? rd_ch : rch_q;
    wire logic [9:0] r_addr = uefm_addr(rreg, rslot_sz, rslot_q[rch_q],
                                       rcnt_q);
    wire logic pop = out_valid_q && out_ready;

    assign rbeat = '{data: rdata, last: rlast_q};

    ////////////////////////////////////////////////////////////////////////
    // Private packet memory, one byte per word
    uefm_ram #(
        .AW(UEFM_AW),
        .DW(UEFM_DW)
    ) u_ram (
        .clk(clk),
        .we(w_mem),
        .waddr(w_addr),
        .wdata(wr_beat.data),
        .re(r_issue),
        .raddr(r_addr),
        .rdata(rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Writer: bulk waits for a free slot, isochronous drops instead
    always_comb begin
        wst_d = wst_q;
        wr_ready_d = wr_ready_q;
        ovf_d = 1'h0;
        unique case (wst_q)
            W_IDLE: if (wr_open && oreg.size != 11'h000) wst_d = W_WAIT;
            W_WAIT: begin
                if (!w_full) begin
                    wst_d = W_DATA;
                    wr_ready_d = 1'h1;
                end else if (w_iso) begin
                    wst_d = W_DROP;
                    wr_ready_d = 1'h1;
                    ovf_d = 1'h1;
                end
            end
            W_DATA, W_DROP: begin
                if (w_beat && wr_beat.last) begin
                    wst_d = W_IDLE;
                    wr_ready_d = 1'h0;
                end
            end
        endcase
    end

    // Hardware set beats the reader's clear on the same flag
    always_comb begin
        full_d = full_q;
        if (r_free) full_d[fch][rslot_q[fch]] = 1'h0;
        if (w_commit) full_d[wch_q][wslot_q[wch_q]] = 1'h1;
    end

    always_comb begin
        for (int i = 0; i < UEFM_NCH; i++) begin
            pkt_d[i] = full_q[i][rslot_q[i]];
            space_d[i] = !full_q[i][wslot_q[i]] &&
                uefm_region(uefm_ch_t'(4'(i)), ep_cfg).size != 11'h000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wst_q <= W_IDLE;
            wr_ready_q <= 1'h0;
            ovf_q <= 1'h0;
            trunc_q <= 1'h0;
            wch_q <= '0;
            wcnt_q <= UEFM_LEN_RST;
            wtrunc_q <= 1'h0;
        end else begin
            wst_q <= wst_d;
            wr_ready_q <= wr_ready_d;
            ovf_q <= ovf_d;
            // Oversized packets are cut at the slot end
            trunc_q <= w_commit && (wtrunc_q || !w_fit);
            if (wst_q == W_IDLE && wr_open) begin
                wch_q <= wr_ch;
                wcnt_q <= UEFM_LEN_RST;
                wtrunc_q <= 1'h0;
            end else begin
                wcnt_q <= wcnt_q + {10'h000, w_mem};
                wtrunc_q <= wtrunc_q || (w_beat && wst_q == W_DATA && !w_fit);
            end
        end
    end

    // Slot bookkeeping; alternate slots when doubled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            full_q <= '{default: '0};
            len_q <= '{default: '{default: UEFM_LEN_RST}};
            wslot_q <= '0;
            rslot_q <= '0;
            cch_q <= '0;
            cslot_q <= 1'h0;
        end else begin
            full_q <= full_d;
            if (w_commit) begin
                len_q[wch_q][wslot_q[wch_q]] <= wcnt_q + {10'h000, w_mem};
                wslot_q[wch_q] <= wslot_q[wch_q] ^ w_dbl;
                cch_q <= wch_q;
                cslot_q <= wslot_q[wch_q];
            end
            if (r_free) rslot_q[fch] <= rslot_q[fch] ^ uefm_dbl(fch, ep_cfg);
        end
    end

    // Reader streams one packet, in write order, into the output buffer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdst_q <= R_IDLE;
            rch_q <= '0;
            rcnt_q <= UEFM_LEN_RST;
            rlen_q <= UEFM_LEN_RST;
            rv_q <= 1'h0;
            rlast_q <= 1'h0;
        end else begin
            rv_q <= r_issue;
            rlast_q <= r_end;
            if (r_go && !r_zero) begin
                rdst_q <= R_RUN;
                rch_q <= rd_ch;
                rcnt_q <= UEFM_LEN_RST;
                rlen_q <= len_q[rd_ch][rslot_q[rd_ch]];
            end else if (r_issue) begin
                rcnt_q <= rcnt_q + 11'h001;
                if (r_end) rdst_q <= R_IDLE;
            end
        end
    end

    // Issue is throttled by occupancy plus the read in flight, so a
    // receiver stall never overruns the buffer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 2'h0;
            h_q <= '0;
            t_q <= '0;
            out_valid_q <= 1'h0;
            pkt_q <= '0;
            space_q <= '0;
        end else begin
            pkt_q <= pkt_d;
            space_q <= space_d;
            if (pop && rv_q) begin
                h_q <= (cnt_q == 2'h2) ? t_q : rbeat;
                t_q <= rbeat;
            end else if (pop) begin
                h_q <= t_q;
                cnt_q <= cnt_q - 2'h1;
                out_valid_q <= cnt_q == 2'h2;
            end else if (rv_q) begin
                if (cnt_q == 2'h0) h_q <= rbeat;
                else t_q <= rbeat;
                cnt_q <= cnt_q + 2'h1;
                out_valid_q <= 1'h1;
            end
        end
    end

    assign wr_ready = wr_ready_q;
    assign out_valid = out_valid_q;
    assign out_beat = h_q;
    assign pkt_avail = pkt_q;
    assign space_avail = space_q;
    assign overflow = ovf_q;
    assign truncated = trunc_q;

    ////////////////////////////////////////////////////////////////////////
    chk_bulk_stall: assert property (
        @(posedge clk) disable iff (rst)
        (wst_q == W_WAIT && w_full && !w_iso) |=>
            (wst_q == W_WAIT && !wr_ready_q))
        else $error("bulk write not stalled on full slot");

    chk_iso_drop: assert property (
        @(posedge clk) disable iff (rst)
        (wst_q == W_WAIT && w_full && w_iso) |=>
            (overflow && wst_q == W_DROP && wr_ready_q) ##1 !overflow)
        else $error("isochronous overflow not flagged once");

    chk_dir_region: assert property (
        @(posedge clk) disable iff (rst)
        (wst_q == W_IDLE && wr_open && oreg.size == 11'h000) |=>
            wst_q == W_IDLE)
        else $error("write opened on a direction with no region");

    chk_slot_alt: assert property (
        @(posedge clk) disable iff (rst)
        (w_commit && w_dbl) |=> wslot_q[cch_q] != cslot_q)
        else $error("double buffer slot did not alternate");

    chk_len_limit: assert property (
        @(posedge clk) disable iff (rst)
        w_commit |=> len_q[cch_q][cslot_q] <= uefm_slot_sz(cch_q, ep_cfg))
        else $error("stored length exceeds slot size");

    chk_wr_window: assert property (
        @(posedge clk) disable iff (rst)
        w_mem |-> ({1'h0, w_addr} >= {1'h0, wreg.base} &&
                   {1'h0, w_addr} < {1'h0, wreg.base} + wreg.size))
        else $error("write outside endpoint region");

    chk_split_sum: assert property (
        @(posedge clk) disable iff (rst)
        (wr_ch.ep != 3'h0 && wr_ch.ep < UEFM_EP_LIMIT &&
         ep_cfg[wr_ch.ep].mode == UEFM_MODE_INOUT) |->
            oreg.size + uefm_region(uefm_ch_t'({wr_ch.ep, !wr_ch.dir_in}),
                ep_cfg).size == UEFM_EP_SIZE[wr_ch.ep])
        else $error("IN/OUT split does not cover the allotment");

    chk_out_hold: assert property (
        @(posedge clk) disable iff (rst)
        (out_valid && !out_ready) |=> (out_valid && $stable(out_beat)))
        else $error("output beat changed while stalled");

    chk_read_empty: assert property (
        @(posedge clk) disable iff (rst)
        (rd_open && rdst_q == R_IDLE && !r_avail) |=> rdst_q == R_IDLE)
        else $error("read started on an empty slot");
endmodule
`default_nettype wire

/* src/uefm_pkg.sv */
// Functional notes
// - Packet streams follow full-speed USB 2.0 device function behaviour.
// - All packet bytes live in one private 1 KB memory for this function.
// - Control endpoint 0 plus five configurable endpoints 1 to 5.
// - Endpoints 1 to 5 are bulk/interrupt or isochronous; traffic handled per type.
// - Endpoints 1 to 5 run as IN only, OUT only, or IN/OUT.
// - Endpoints 1 to 5 may hold two packets at once (double buffering).
// - Allotments: endpoint 0 32 bytes, endpoint 1 32, endpoint 2 64.
// - Allotments: endpoint 3 128 bytes, endpoint 4 256, endpoint 5 512.
// - IN/OUT endpoints split their allotment by an application-chosen share.
package uefm_pkg;

    localparam int UEFM_NUM_EP = 6;
    localparam int UEFM_NCH = 12;
    localparam int UEFM_AW = 10;
    localparam int UEFM_DW = 8;

    // Allotment table, endpoint 0 first
    localparam logic [9:0] UEFM_EP_BASE [UEFM_NUM_EP] = '{
        10'h000, 10'h020, 10'h040, 10'h080, 10'h100, 10'h200};
    localparam logic [10:0] UEFM_EP_SIZE [UEFM_NUM_EP] = '{
        11'h020, 11'h020, 11'h040, 11'h080, 11'h100, 11'h200};
    localparam logic [2:0] UEFM_EP_LIMIT = 3'h6;
    localparam logic [10:0] UEFM_LEN_RST = 11'h000;

    typedef enum logic [1:0] {
        UEFM_MODE_OUT,
        UEFM_MODE_IN,
        UEFM_MODE_INOUT
    } uefm_mode_t;

    typedef enum logic [1:0] {W_IDLE, W_WAIT, W_DATA, W_DROP} uefm_wst_t;
    typedef enum logic {R_IDLE, R_RUN} uefm_rdst_t;

    typedef struct packed {
        logic iso;
        uefm_mode_t mode;
        logic dbl;
        logic [9:0] in_share;
    } uefm_ep_cfg_t;

    typedef uefm_ep_cfg_t [UEFM_NUM_EP-1:0] uefm_cfg_arr_t;

    typedef struct packed {
        logic [2:0] ep;
        logic dir_in;
    } uefm_ch_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } uefm_beat_t;

    typedef struct packed {
        logic [9:0] base;
        logic [10:0] size;
    } uefm_region_t;

    function automatic uefm_region_t uefm_region(uefm_ch_t ch,
                                                 uefm_cfg_arr_t cfg);
        uefm_region_t r;
        logic [10:0] in_sz;
        r = '0;
        in_sz = 11'h000;
        if (ch.ep < UEFM_EP_LIMIT) begin
            r.base = UEFM_EP_BASE[ch.ep];
            r.size = UEFM_EP_SIZE[ch.ep];
            in_sz = {1'h0, cfg[ch.ep].in_share};
            if (in_sz > r.size) begin
                in_sz = r.size;
            end
            // Endpoint 0 shares its whole region in both directions
            if (ch.ep != 3'h0) begin
                unique case (cfg[ch.ep].mode)
                    UEFM_MODE_OUT: if (ch.dir_in) r.size = 11'h000;
                    UEFM_MODE_IN: if (!ch.dir_in) r.size = 11'h000;
                    UEFM_MODE_INOUT: begin
                        if (ch.dir_in) begin
                            r.size = in_sz;
                        end else begin
                            r.base = r.base + in_sz[9:0];
                            r.size = r.size - in_sz;
                        end
                    end
                    default: r.size = 11'h000;
                endcase
            end
        end
        return r;
    endfunction

    function automatic logic uefm_dbl(uefm_ch_t ch, uefm_cfg_arr_t cfg);
        return ch.ep != 3'h0 && ch.ep < UEFM_EP_LIMIT && cfg[ch.ep].dbl;
    endfunction

    function automatic logic [10:0] uefm_slot_sz(uefm_ch_t ch,
                                                 uefm_cfg_arr_t cfg);
        uefm_region_t r;
        r = uefm_region(ch, cfg);
        return uefm_dbl(ch, cfg) ? {1'h0, r.size[10:1]} : r.size;
    endfunction

    function automatic logic [9:0] uefm_addr(uefm_region_t r,
                                             logic [10:0] ssz, logic slot,
                                             logic [10:0] cnt);
        logic [10:0] a;
        a = {1'h0, r.base} + (slot ? ssz : 11'h000) + cnt;
        return a[9:0];
    endfunction

endpackage

/* src/uefm_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module uefm_ram #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    // Reader only touches full slots, writer only empty ones: no collision, except on endpoint 0, whose two directions share one region
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

/* verification/uefm_host_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module uefm_host_sink
    import uefm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic out_valid,
    input wire uefm_beat_t out_beat,
    output logic out_ready
);
    logic [1:0] pace_q;
    uefm_beat_t got[$];

    ////////////////////////////////////////////////////////////////////
    // Slow mode takes one beat in four, so the output buffer backs up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pace_q <= 2'h0;
        end else begin
            pace_q <= pace_q + 2'h1;
        end
    end
    assign out_ready = !slow || pace_q == 2'h3;

    ////////////////////////////////////////////////////////////////////
    // Every beat taken is kept in arrival order
    always @(posedge clk) begin
        if (!rst && out_valid === 1'b1 && out_ready) begin
            got.push_back(out_beat);
        end
    end
endmodule
`default_nettype wire

/* verification/usb_endpoint_fifo_memory_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_fifo_memory_tb_top;
    import uefm_pkg::*;
    logic clk, rst, wr_open, wr_valid, wr_ready, rd_open;
    logic out_valid, out_ready, overflow, truncated, slow;
    uefm_cfg_arr_t ep_cfg;
    uefm_ch_t wr_ch, rd_ch;
    uefm_beat_t wr_beat, out_beat;
    logic [UEFM_NCH-1:0] pkt_avail, space_avail;
    int errors, num_checks, cycles, n_trunc, n_ovf;

    uefm_core i_dut (.clk(clk), .rst(rst), .ep_cfg(ep_cfg),
        .wr_open(wr_open), .wr_ch(wr_ch), .wr_valid(wr_valid),
        .wr_beat(wr_beat), .wr_ready(wr_ready), .rd_open(rd_open),
        .rd_ch(rd_ch), .out_valid(out_valid), .out_beat(out_beat),
        .out_ready(out_ready), .pkt_avail(pkt_avail),
        .space_avail(space_avail), .overflow(overflow),
        .truncated(truncated));
    uefm_host_sink i_sink (.clk(clk), .rst(rst), .slow(slow),
        .out_valid(out_valid), .out_beat(out_beat),
        .out_ready(out_ready));

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    // Pulse counters, so a late pulse by a cycle is still seen
    always @(posedge clk) begin
        cycles++;
        if (!rst && truncated === 1'b1) n_trunc++;
        if (!rst && overflow === 1'b1) n_ovf++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic uefm_ep_cfg_t mk(input logic iso, input uefm_mode_t m,
                                        input logic dbl, input logic [9:0] sh);
        return '{iso, m, dbl, sh};
    endfunction

    ////////////////////////////////////////////////////////////////////
    task automatic open_wr(input logic [3:0] ch);
        wr_open = 1'h1;
        wr_ch = ch;
        @(posedge clk); #1;
        wr_open = 1'h0;
    endtask

    // Bound on the ready wait keeps a stuck writer from hanging the run
    task automatic send(input int len, input logic [7:0] seed);
        int n;
        n = 0;
        while (wr_ready !== 1'b1 && n < 50) begin
            @(posedge clk); #1;
            n++;
        end
        chk("wr_ready", 32'h1, {31'h0, wr_ready});
        for (int i = 0; i < len; i++) begin
            wr_valid = 1'h1;
            wr_beat = '{seed + i[7:0], i == len - 1};
            @(posedge clk); #1;
        end
        wr_valid = 1'h0;
        wr_beat = '0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic write_pkt(input logic [3:0] ch, input int len,
                             input logic [7:0] seed);
        open_wr(ch);
        send(len, seed);
    endtask

    task automatic read_pkt(input logic [3:0] ch, input int len,
                            input logic [7:0] seed);
        int n;
        uefm_beat_t b;
        logic [7:0] e;
        n = 0;
        while (pkt_avail[ch] !== 1'b1 && n < 20) begin
            @(posedge clk); #1;
            n++;
        end
        i_sink.got.delete();
        rd_open = 1'h1;
        rd_ch = ch;
        @(posedge clk); #1;
        rd_open = 1'h0;
        n = 0;
        while (i_sink.got.size() < len && n < 3000) begin
            @(posedge clk); #1;
            n++;
        end
        repeat (6) @(posedge clk);
        #1;
        chk("read_len", 32'(len), 32'(i_sink.got.size()));
        for (int i = 0; i < len && i < i_sink.got.size(); i++) begin
            b = i_sink.got[i];
            // Byte-wide sum, so long packets wrap like the stored data
            e = seed + i[7:0];
            chk("read_data", {24'h0, e}, {24'h0, b.data});
            chk("read_last", 32'(i == len - 1), {31'h0, b.last});
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        repeat (2) @(posedge clk);
        #1;
        chk("space_during_reset", 32'h0, {20'h0, space_avail});
        chk("pkt_during_reset", 32'h0, {20'h0, pkt_avail});
        @(posedge clk); #1;
        rst = 1'h0;
        repeat (2) @(posedge clk);
        #1;
        chk("space_after_reset", 32'hba7, {20'h0, space_avail});
    endtask

    // Regions of endpoints 0, 3, 4 and 5 full at once, then drained: overlaps would corrupt data
    task automatic t_regions();
        write_pkt(4'h7, 64, 8'h10);
        chk("space_second_slot", 32'h1, {31'h0, space_avail[7]});
        write_pkt(4'h7, 65, 8'h20);
        chk("space_both_full", 32'h0, {31'h0, space_avail[7]});
        write_pkt(4'h9, 65, 8'h30);
        write_pkt(4'h8, 192, 8'h40);
        write_pkt(4'hb, 512, 8'h50);
        write_pkt(4'h0, 32, 8'h60);
        chk("trunc_count", 32'h2, 32'(n_trunc));
        slow = 1'h1;
        read_pkt(4'h7, 64, 8'h10);
        read_pkt(4'h7, 64, 8'h20);
        read_pkt(4'h9, 64, 8'h30);
        read_pkt(4'h8, 192, 8'h40);
        read_pkt(4'hb, 512, 8'h50);
        slow = 1'h0;
        read_pkt(4'h0, 32, 8'h60);
    endtask

    // Open on a direction with no region is ignored; writer stays idle
    task automatic t_trunc();
        open_wr(4'h3);
        repeat (4) @(posedge clk);
        #1;
        chk("no_region_ready", 32'h0, {31'h0, wr_ready});
        chk("no_region_space", 32'h0, {31'h0, space_avail[3]});
        write_pkt(4'h2, 33, 8'h70);
        chk("trunc_count", 32'h3, 32'(n_trunc));
        read_pkt(4'h2, 32, 8'h70);
    endtask

    // Isochronous drops the packet when full; bulk holds the writer off
    task automatic t_types();
        write_pkt(4'h5, 20, 8'h80);
        write_pkt(4'h5, 8, 8'h90);
        chk("ovf_count", 32'h1, 32'(n_ovf));
        read_pkt(4'h5, 20, 8'h80);
        chk("iso_no_extra", 32'h0, {31'h0, pkt_avail[5]});
        write_pkt(4'h2, 4, 8'ha0);
        open_wr(4'h2);
        repeat (8) @(posedge clk);
        #1;
        chk("bulk_hold", 32'h0, {31'h0, wr_ready});
        read_pkt(4'h2, 4, 8'ha0);
        send(4, 8'hb0);
        read_pkt(4'h2, 4, 8'hb0);
        chk("ovf_final", 32'h1, 32'(n_ovf));
    endtask

    initial begin
        rst = 1'h1;
        wr_open = 1'h0;
        wr_ch = '0;
        wr_valid = 1'h0;
        wr_beat = '0;
        rd_open = 1'h0;
        rd_ch = '0;
        slow = 1'h0;
        ep_cfg[0] = mk(1'h0, UEFM_MODE_INOUT, 1'h0, 10'h000);
        ep_cfg[1] = mk(1'h0, UEFM_MODE_OUT, 1'h0, 10'h000);
        ep_cfg[2] = mk(1'h1, UEFM_MODE_IN, 1'h0, 10'h000);
        ep_cfg[3] = mk(1'h0, UEFM_MODE_IN, 1'h1, 10'h000);
        ep_cfg[4] = mk(1'h0, UEFM_MODE_INOUT, 1'h0, 10'h040);
        ep_cfg[5] = mk(1'h0, UEFM_MODE_IN, 1'h0, 10'h000);
        t_reset();
        t_regions();
        t_trunc();
        t_types();
        tally_and_finish();
    end
endmodule
`default_nettype wire
